// *** host_port_pkg.sv ***
package host_port_pkg;

   // ************************************************************
   // lane widths and pin positions
   // ************************************************************
   localparam int BYTE_W = 8;
   localparam int CTRL_W = 6;
   localparam int GPIO_CTRL_W = 5;

   // uart lane positions
   localparam int UART_TXD_BIT = 0;
   localparam int UART_RXD_BIT = 1;
   localparam int UART_RTS_BIT = 2;
   localparam int UART_CTS_BIT = 3;
   localparam int UART_DTR_BIT = 4;
   localparam int UART_DSR_BIT = 5;
   localparam int UART_DCD_BIT = 6;
   localparam int UART_RI_BIT = 7;
   localparam int UART_RS485_TX_ENABLE_N_BIT = 0;

   // fifo control lane positions
   localparam int FIFO_RXF_BIT = 0;
   localparam int FIFO_TXE_BIT = 1;
   localparam int FIFO_WR_BIT = 2;
   localparam int FIFO_RD_BIT = 3;

   // spi lane positions
   localparam int SPI_SCLK_BIT = 0;
   localparam int SPI_SDI_BIT = 1;
   localparam int SPI_SDO_BIT = 2;
   localparam int SPI_CS_BIT = 3;

   // ************************************************************
   // direction masks (output enable low = pin driven)
   // ************************************************************
   localparam logic [7:0] UART_BYTE_OE_N = 8'hEA;
   localparam logic [5:0] FIFO_CTRL_OE_N = 6'h3C;
   localparam logic [7:0] SPI_BYTE_OE_N = 8'hFB;
   localparam logic [7:0] BYTE_OE_N_IDLE = 8'hFF;
   localparam logic [5:0] CTRL_OE_N_IDLE = 6'h3F;

   // ************************************************************
   // modes and state
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_UART = 2'b00,
      MODE_FIFO = 2'b01,
      MODE_SPI = 2'b10
   } mode_type;

   typedef struct packed {
      logic latched;
      mode_type mode;
      logic fw_load;
      logic [7:0] byte_o;
      logic [7:0] byte_oe_n;
      logic [5:0] ctrl_o;
      logic [5:0] ctrl_oe_n;
      logic [7:0] uart_in;
      logic uart_rs485_tx_enable_n_n;
      logic [7:0] fifo_data;
      logic fifo_wr;
      logic fifo_rd_n;
      logic [2:0] spi_in;
      logic [7:0] gpio_byte_in;
      logic [4:0] gpio_ctrl_in;
   } state_type;

   // values after reset: all pins released, handshakes idle
   localparam state_type ST_RESET = '{
      latched: 1'b0, mode: MODE_UART, fw_load: 1'b0,
      byte_o: 8'h00, byte_oe_n: 8'hFF, ctrl_o: 6'h00, ctrl_oe_n: 6'h3F,
      uart_in: 8'hFF, uart_rs485_tx_enable_n_n: 1'b1, fifo_data: 8'h00, fifo_wr: 1'b0,
      fifo_rd_n: 1'b1, spi_in: 3'h4, gpio_byte_in: 8'h00, gpio_ctrl_in: 5'h00};

   // strap decode: both high or both low give uart
   function automatic mode_type decode_mode(input logic upper, input logic lower);
      mode_type m;
      m = MODE_UART;
      if (upper && !lower) begin
         m = MODE_SPI;
      end else if (!upper && lower) begin
         m = MODE_FIFO;
      end
      return m;
   endfunction

endpackage

// *** pin_sync2.sv ***
`timescale 1ns/10ps
module pin_sync2 #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } sync_state_type;

   sync_state_type st_q;
   sync_state_type st_d;

   initial begin
      if (WIDTH < 1) begin
         $error("pin_sync2 width must be at least one");
      end
   end

   // two flops; the first is read only by the second
   always_comb begin
      st_d.meta = async_i;
      st_d.sync = st_q.meta;
      if (srst_i) begin
         st_d = '0;
      end
   end

   // state register for both stages
   always_ff @(posedge clk_i) begin
      st_q <= st_d;
   end

   assign sync_o = st_q.sync;
endmodule

// *** host_port_mode_pin_mux.sv ***
// Operation
// - straps decode mode: 11 uart, 10 spi, 01 fifo, 00 uart.
// - uart maps byte lane to txd..ri, control bit 0 to rs485 enable.
// - fifo carries data on byte lane; control 0..3 rxf, txe, wr, rd.
// - spi uses bit0 clock, bit1 data in, bit3 select, drives bit2 out.
// - gpio exposes byte lane 0..7 and control lane 0..4 bidirectionally.
// - active-low external reset returns the state register to initial state; the pin synchronisers clear on SRST_I only.
// - firmware-load input held at reset release requests firmware via host port.
// - every lane pin except control bit 5 (never driven) is bidirectional, direction set by mode or port config.
`timescale 1ns/10ps
module host_port_mode_pin_mux
   import host_port_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic SRST_I,
   // board pins
   input wire logic MODE_STRAP_LOWER_I,
   input wire logic MODE_STRAP_UPPER_I,
   input wire logic RESET_N_I,
   input wire logic FIRMWARE_LOAD_N_I,
   // byte lane pin (three signals per pin)
   input wire logic [host_port_pkg::BYTE_W-1:0] BYTE_LANE_I,
   output logic [host_port_pkg::BYTE_W-1:0] BYTE_LANE_O,
   output logic [host_port_pkg::BYTE_W-1:0] BYTE_LANE_OE_N_O,
   // control lane pins
   input wire logic [host_port_pkg::CTRL_W-1:0] CTRL_LANE_I,
   output logic [host_port_pkg::CTRL_W-1:0] CTRL_LANE_O,
   output logic [host_port_pkg::CTRL_W-1:0] CTRL_LANE_OE_N_O,
   // block status
   output logic MODE_VALID_O,
   output logic [1:0] MODE_O,
   output logic FIRMWARE_LOAD_O,
   // uart core side
   input wire logic UART_TXD_I,
   input wire logic UART_RTS_N_I,
   input wire logic UART_DTR_N_I,
   output logic UART_RXD_O,
   output logic UART_CTS_N_O,
   output logic UART_DSR_N_O,
   output logic UART_DCD_N_O,
   output logic UART_RI_N_O,
   output logic RS485_TX_ENABLE_N_O,
   // fifo core side
   input wire logic [7:0] FIFO_RD_DATA_I,
   input wire logic FIFO_RD_DATA_OE_I,
   input wire logic RX_DATA_AVAILABLE_N_I,
   input wire logic TX_SPACE_AVAILABLE_N_I,
   output logic [7:0] FIFO_WR_DATA_O,
   output logic FIFO_WR_O,
   output logic FIFO_RD_N_O,
   // spi core side
   input wire logic SPI_SDO_I,
   output logic SPI_SCLK_O,
   output logic SPI_SDI_O,
   output logic SPI_CS_O,
   // general-purpose port side
   input wire logic GPIO_MODE_I,
   input wire logic [7:0] GPIO_BYTE_OUT_I,
   input wire logic [7:0] GPIO_BYTE_DIR_I,
   input wire logic [4:0] GPIO_CTRL_OUT_I,
   input wire logic [4:0] GPIO_CTRL_DIR_I,
   output logic [7:0] GPIO_BYTE_IN_O,
   output logic [4:0] GPIO_CTRL_IN_O
);
   import host_port_pkg::*;

   localparam int SYNC_W = BYTE_W + CTRL_W + 4;

   logic [SYNC_W-1:0] pins_s;
   logic [7:0] byte_s;
   logic [5:0] ctrl_s;
   logic strap_lower_s;
   logic strap_upper_s;
   logic reset_n_s;
   logic fw_load_n_s;
   logic rst_int;
   state_type st_q;
   state_type st_d;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   pin_sync2 #(.WIDTH(SYNC_W)) u_pin_sync (
      .clk_i(SYS_CLK_I),
      .srst_i(SRST_I),
      .async_i({FIRMWARE_LOAD_N_I, RESET_N_I, MODE_STRAP_UPPER_I, MODE_STRAP_LOWER_I, CTRL_LANE_I, BYTE_LANE_I}),
      .sync_o(pins_s)
   );

   assign byte_s = pins_s[7:0];
   assign ctrl_s = pins_s[13:8];
   assign strap_lower_s = pins_s[14];
   assign strap_upper_s = pins_s[15];
   assign reset_n_s = pins_s[16];
   assign fw_load_n_s = pins_s[17];

   // external reset joins the system reset so the state register restarts; the synchronisers clear on SRST_I only
   assign rst_int = SRST_I | ~reset_n_s;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      st_d = st_q;
      if (rst_int) begin
         st_d = ST_RESET;
      end else if (!st_q.latched) begin
         // first cycle after release: capture straps once
         st_d.latched = 1'b1;
         st_d.mode = decode_mode(strap_upper_s, strap_lower_s);
         st_d.fw_load = ~fw_load_n_s;
      end else begin
         // idle defaults; only the active interface overrides them
         st_d.byte_o = 8'h00;
         st_d.byte_oe_n = BYTE_OE_N_IDLE;
         st_d.ctrl_o = 6'h00;
         st_d.ctrl_oe_n = CTRL_OE_N_IDLE;
         st_d.uart_in = 8'hFF;
         st_d.uart_rs485_tx_enable_n_n = 1'b1;
         st_d.fifo_wr = 1'b0;
         st_d.fifo_rd_n = 1'b1;
         st_d.spi_in = 3'h4;
         if (GPIO_MODE_I) begin
            st_d.byte_o = GPIO_BYTE_OUT_I;
            st_d.byte_oe_n = ~GPIO_BYTE_DIR_I;
            st_d.ctrl_o = {1'b0, GPIO_CTRL_OUT_I};
            st_d.ctrl_oe_n = {1'b1, ~GPIO_CTRL_DIR_I};
            st_d.gpio_byte_in = byte_s;
            st_d.gpio_ctrl_in = ctrl_s[4:0];
         end else begin
            case (st_q.mode)
               MODE_UART: begin
                  st_d.byte_o[UART_TXD_BIT] = UART_TXD_I;
                  st_d.byte_o[UART_RTS_BIT] = UART_RTS_N_I;
                  st_d.byte_o[UART_DTR_BIT] = UART_DTR_N_I;
                  st_d.byte_oe_n = UART_BYTE_OE_N;
                  st_d.uart_in = byte_s;
                  st_d.uart_rs485_tx_enable_n_n = ctrl_s[UART_RS485_TX_ENABLE_N_BIT];
               end
               MODE_FIFO: begin
                  // the byte lane is driven only while the core holds FIFO_RD_DATA_OE_I high
                  st_d.byte_o = FIFO_RD_DATA_I;
                  st_d.byte_oe_n = FIFO_RD_DATA_OE_I ? 8'h00 : BYTE_OE_N_IDLE;
                  st_d.ctrl_o[FIFO_RXF_BIT] = RX_DATA_AVAILABLE_N_I;
                  st_d.ctrl_o[FIFO_TXE_BIT] = TX_SPACE_AVAILABLE_N_I;
                  st_d.ctrl_oe_n = FIFO_CTRL_OE_N;
                  st_d.fifo_data = byte_s;
                  st_d.fifo_wr = ctrl_s[FIFO_WR_BIT];
                  st_d.fifo_rd_n = ctrl_s[FIFO_RD_BIT];
               end
               MODE_SPI: begin
                  st_d.byte_o[SPI_SDO_BIT] = SPI_SDO_I;
                  st_d.byte_oe_n = SPI_BYTE_OE_N;
                  st_d.spi_in = {byte_s[SPI_CS_BIT], byte_s[SPI_SDI_BIT], byte_s[SPI_SCLK_BIT]};
               end
               default: begin
                  st_d.byte_oe_n = BYTE_OE_N_IDLE;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge SYS_CLK_I) begin
      st_q <= st_d;
   end

   // outputs, all straight from the state register
   assign BYTE_LANE_O = st_q.byte_o;
   assign BYTE_LANE_OE_N_O = st_q.byte_oe_n;
   assign CTRL_LANE_O = st_q.ctrl_o;
   assign CTRL_LANE_OE_N_O = st_q.ctrl_oe_n;
   assign MODE_VALID_O = st_q.latched;
   assign MODE_O = st_q.mode;
   assign FIRMWARE_LOAD_O = st_q.fw_load;
   assign UART_RXD_O = st_q.uart_in[UART_RXD_BIT];
   assign UART_CTS_N_O = st_q.uart_in[UART_CTS_BIT];
   assign UART_DSR_N_O = st_q.uart_in[UART_DSR_BIT];
   assign UART_DCD_N_O = st_q.uart_in[UART_DCD_BIT];
   assign UART_RI_N_O = st_q.uart_in[UART_RI_BIT];
   assign RS485_TX_ENABLE_N_O = st_q.uart_rs485_tx_enable_n_n;
   assign FIFO_WR_DATA_O = st_q.fifo_data;
   assign FIFO_WR_O = st_q.fifo_wr;
   assign FIFO_RD_N_O = st_q.fifo_rd_n;
   assign SPI_SCLK_O = st_q.spi_in[0];
   assign SPI_SDI_O = st_q.spi_in[1];
   assign SPI_CS_O = st_q.spi_in[2];
   assign GPIO_BYTE_IN_O = st_q.gpio_byte_in;
   assign GPIO_CTRL_IN_O = st_q.gpio_ctrl_in;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (SRST_I);

   logic run;
   assign run = !rst_int && st_q.latched && !GPIO_MODE_I;

   chk_mode_decode: assert property (
      !rst_int && !st_q.latched |=> st_q.latched && st_q.mode == decode_mode($past(strap_upper_s), $past(strap_lower_s)))
      else $error("strap decode wrong");
   chk_mode_held: assert property (
      st_q.latched && !rst_int |=> $stable(st_q.mode) && st_q.latched)
      else $error("mode changed without reset");
   chk_uart_txd_path: assert property (
      run && st_q.mode == MODE_UART |=> BYTE_LANE_O[0] == $past(UART_TXD_I) && BYTE_LANE_OE_N_O == 8'hEA)
      else $error("uart txd mapping wrong");
   chk_uart_rxd_path: assert property (
      run && st_q.mode == MODE_UART |=> UART_RXD_O == $past(byte_s[1]) && RS485_TX_ENABLE_N_O == $past(ctrl_s[0]))
      else $error("uart input mapping wrong");
   chk_fifo_flags_out: assert property (
      run && st_q.mode == MODE_FIFO |=>
         CTRL_LANE_O[1:0] == $past({TX_SPACE_AVAILABLE_N_I, RX_DATA_AVAILABLE_N_I}) && CTRL_LANE_OE_N_O == 6'h3C)
      else $error("fifo flags mapping wrong");
   chk_spi_sdo_out: assert property (
      run && st_q.mode == MODE_SPI |=> BYTE_LANE_O[2] == $past(SPI_SDO_I) && CTRL_LANE_OE_N_O == 6'h3F)
      else $error("spi mapping wrong");
   chk_gpio_dir_out: assert property (
      !rst_int && st_q.latched && GPIO_MODE_I |=>
         BYTE_LANE_OE_N_O == ~$past(GPIO_BYTE_DIR_I) && BYTE_LANE_O == $past(GPIO_BYTE_OUT_I))
      else $error("gpio port mapping wrong");
   chk_gpio_ctrl_dir: assert property (
      !rst_int && st_q.latched && GPIO_MODE_I |=> CTRL_LANE_OE_N_O == {1'b1, ~$past(GPIO_CTRL_DIR_I)})
      else $error("gpio control direction wrong");
   chk_ext_reset_idle: assert property (
      !reset_n_s |=> !MODE_VALID_O && BYTE_LANE_OE_N_O == 8'hFF && CTRL_LANE_OE_N_O == 6'h3F)
      else $error("external reset did not release pins");
   chk_fw_load_flag: assert property (
      !rst_int && !st_q.latched |=> FIRMWARE_LOAD_O == !$past(fw_load_n_s))
      else $error("firmware load flag wrong");

   cov_uart_mode: cover property (st_q.latched && st_q.mode == MODE_UART && !GPIO_MODE_I);
   cov_fifo_mode: cover property (st_q.latched && st_q.mode == MODE_FIFO && FIFO_RD_DATA_OE_I);
   cov_spi_mode: cover property (st_q.latched && st_q.mode == MODE_SPI);
   cov_fw_load: cover property (st_q.latched && st_q.fw_load);
endmodule

// *** host_partner.sv ***
`timescale 1ns/10ps
module host_partner (
   // clock
   input wire logic clk_i,
   // jumpers and host control requests
   input wire logic [1:0] jumper_i,
   input wire logic rst_req_i,
   input wire logic fw_req_i,
   // lanes: bits 7:0 byte lane, 13:8 control lane
   input wire logic [13:0] host_v_i,
   input wire logic [13:0] host_en_i,
   input wire logic [13:0] dev_v_i,
   input wire logic [13:0] dev_oe_n_i,
   // resolved pins
   output logic strap_upper_o,
   output logic strap_lower_o,
   output logic reset_n_o,
   output logic fw_load_n_o,
   output logic [13:0] wire_o
);
   logic [13:0] float_q = 14'h2AAA;
   // jumper pulls hold each strap steady
   assign strap_upper_o = jumper_i[1];
   assign strap_lower_o = jumper_i[0];
   // host pulls reset and firmware-load low on request
   assign reset_n_o = !rst_req_i;
   assign fw_load_n_o = !fw_req_i;
   // an undriven pin toggles so a stale value never reads as held
   always @(posedge clk_i) begin
      float_q <= ~float_q;
   end
   // device drive wins, then host drive, else floating
   always_comb begin
      for (int i = 0; i < 14; i++) begin
         wire_o[i] = !dev_oe_n_i[i] ? dev_v_i[i] : (host_en_i[i] ? host_v_i[i] : float_q[i]);
      end
   end
endmodule

// *** host_port_mode_pin_mux_tb.sv ***
`timescale 1ns/10ps
module host_port_mode_pin_mux_tb;
   import host_port_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [1:0] jumper = 2'b11;
   logic rst_req = 1'b0;
   logic fw_req = 1'b0;
   logic [13:0] host_v = 14'h0000;
   logic [13:0] host_en = 14'h0000;
   logic [2:0] u_in = 3'h7;
   logic [7:0] f_dat = 8'h00;
   logic f_oe = 1'b0;
   logic [1:0] f_flg = 2'h3;
   logic sdo = 1'b0;
   logic g_mode = 1'b0;
   logic [7:0] g_bo = 8'h00;
   logic [7:0] g_bd = 8'h00;
   logic [4:0] g_co = 5'h00;
   logic [4:0] g_cd = 5'h00;
   logic s_up, s_lo, rst_n, fw_n, valid, fw_flag, rxd, cts, dsr, dcd, ri, rs485_tx_enable_n, f_wr, f_rd_n, sclk, sdi, cs;
   logic [13:0] pins;
   logic [7:0] b_o, b_oe, wr_data, g_bi;
   logic [5:0] c_o, c_oe;
   logic [1:0] mode;
   logic [4:0] g_ci;
   int n_mismatch = 0;
   int tests_run = 0;
   always #12.5 clk = ~clk;
   host_partner u_host_partner (.clk_i(clk), .jumper_i(jumper), .rst_req_i(rst_req), .fw_req_i(fw_req),
      .host_v_i(host_v), .host_en_i(host_en), .dev_v_i({c_o, b_o}), .dev_oe_n_i({c_oe, b_oe}),
      .strap_upper_o(s_up), .strap_lower_o(s_lo), .reset_n_o(rst_n), .fw_load_n_o(fw_n), .wire_o(pins));
   host_port_mode_pin_mux u_host_port_mode_pin_mux (.SYS_CLK_I(clk), .SRST_I(srst),
      .MODE_STRAP_LOWER_I(s_lo), .MODE_STRAP_UPPER_I(s_up), .RESET_N_I(rst_n), .FIRMWARE_LOAD_N_I(fw_n),
      .BYTE_LANE_I(pins[7:0]), .BYTE_LANE_O(b_o), .BYTE_LANE_OE_N_O(b_oe),
      .CTRL_LANE_I(pins[13:8]), .CTRL_LANE_O(c_o), .CTRL_LANE_OE_N_O(c_oe),
      .MODE_VALID_O(valid), .MODE_O(mode), .FIRMWARE_LOAD_O(fw_flag),
      .UART_TXD_I(u_in[0]), .UART_RTS_N_I(u_in[1]), .UART_DTR_N_I(u_in[2]), .UART_RXD_O(rxd),
      .UART_CTS_N_O(cts), .UART_DSR_N_O(dsr), .UART_DCD_N_O(dcd), .UART_RI_N_O(ri),
      .RS485_TX_ENABLE_N_O(rs485_tx_enable_n), .FIFO_RD_DATA_I(f_dat), .FIFO_RD_DATA_OE_I(f_oe),
      .RX_DATA_AVAILABLE_N_I(f_flg[0]), .TX_SPACE_AVAILABLE_N_I(f_flg[1]), .FIFO_WR_DATA_O(wr_data),
      .FIFO_WR_O(f_wr), .FIFO_RD_N_O(f_rd_n), .SPI_SDO_I(sdo), .SPI_SCLK_O(sclk), .SPI_SDI_O(sdi),
      .SPI_CS_O(cs), .GPIO_MODE_I(g_mode), .GPIO_BYTE_OUT_I(g_bo), .GPIO_BYTE_DIR_I(g_bd),
      .GPIO_CTRL_OUT_I(g_co), .GPIO_CTRL_DIR_I(g_cd), .GPIO_BYTE_IN_O(g_bi), .GPIO_CTRL_IN_O(g_ci));
   // ****************
   // helpers
   // ****************
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // pin inputs need two sync edges plus one register edge, so wait four
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_valid();
      int k;
      k = 0;
      while (valid !== 1'b1 && k < 8) begin
         step(1);
         k++;
      end
      if (valid !== 1'b1) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask
   task automatic start(input logic [1:0] jmp, input logic fw);
      @(posedge clk);
      srst <= 1'b1;
      jumper <= jmp;
      fw_req <= fw;
      step(2);
      check("oe_byte_rst", b_oe, 8'hFF);
      check("valid_rst", {7'h00, valid}, 8'h00);
      @(posedge clk);
      srst <= 1'b0;
      wait_valid();
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_straps();
      mode_type exp [4];
      exp = '{MODE_UART, MODE_FIFO, MODE_SPI, MODE_UART};
      for (int j = 0; j < 4; j++) begin
         start(2'(j), 1'b0);
         check("mode", {6'h00, mode}, {6'h00, exp[j]});
      end
      @(posedge clk);
      jumper <= 2'b01;
      step(6);
      check("mode_kept", {6'h00, mode}, {6'h00, MODE_UART});
   endtask
   task automatic t_uart();
      logic [13:0] hv;
      start(2'b11, 1'b0);
      for (int p = 0; p < 2; p++) begin
         hv = p ? 14'h0148 : 14'h00A2;
         @(posedge clk);
         u_in <= p ? 3'b010 : 3'b101;
         host_en <= 14'h01EA;
         host_v <= hv;
         step(4);
         check("uart_oe", b_oe, UART_BYTE_OE_N);
         check("uart_pin_out", pins[7:0] & 8'h15, {3'h0, u_in[2], 1'b0, u_in[1], 1'b0, u_in[0]});
         check("uart_core_in", {2'h0, ri, dcd, dsr, cts, rxd, rs485_tx_enable_n}, {2'h0, hv[7:5], hv[3], hv[1], hv[8]});
      end
   endtask
   task automatic t_fifo();
      start(2'b01, 1'b0);
      @(posedge clk);
      host_en <= 14'h0CFF;
      host_v <= 14'h045A;
      f_flg <= 2'b10;
      step(4);
      check("fifo_ctrl_oe", {2'h0, c_oe}, {2'h0, FIFO_CTRL_OE_N});
      check("fifo_wr_data", wr_data, 8'h5A);
      check("fifo_strobes", {6'h00, f_wr, f_rd_n}, 8'h02);
      check("fifo_flags", {6'h00, pins[9:8]}, 8'h02);
      @(posedge clk);
      host_en <= 14'h0C00;
      f_oe <= 1'b1;
      f_dat <= 8'hC3;
      step(2);
      check("fifo_rd_pins", pins[7:0], 8'hC3);
      check("fifo_rd_oe", b_oe, 8'h00);
      @(posedge clk);
      f_oe <= 1'b0;
      step(2);
      check("fifo_release", b_oe, 8'hFF);
   endtask
   task automatic t_spi();
      start(2'b10, 1'b0);
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         host_en <= 14'h000B;
         host_v <= p ? 14'h0002 : 14'h0009;
         sdo <= !p;
         step(4);
         check("spi_core_in", {5'h00, sclk, sdi, cs}, p ? 8'h02 : 8'h05);
         check("spi_sdo_pin", {7'h00, pins[2]}, {7'h00, !p});
         check("spi_oe_byte", b_oe, SPI_BYTE_OE_N);
         check("spi_oe_ctrl", {2'h0, c_oe}, {2'h0, CTRL_OE_N_IDLE});
      end
   endtask
   task automatic t_gpio();
      start(2'b11, 1'b0);
      @(posedge clk);
      g_mode <= 1'b1;
      g_bd <= 8'h0F;
      g_bo <= 8'h05;
      g_cd <= 5'h03;
      g_co <= 5'h01;
      host_en <= 14'h1CF0;
      host_v <= 14'h1490;
      step(4);
      check("gpio_oe_byte", b_oe, 8'hF0);
      check("gpio_oe_ctrl", {2'h0, c_oe}, 8'h3C);
      check("gpio_byte_in", g_bi, 8'h95);
      check("gpio_ctrl_in", {3'h0, g_ci}, 8'h15);
      @(posedge clk);
      g_mode <= 1'b0;
      host_en <= 14'h0000;
   endtask
   task automatic t_reset();
      start(2'b11, 1'b1);
      check("fw_flag_set", {7'h00, fw_flag}, 8'h01);
      @(posedge clk);
      fw_req <= 1'b0;
      rst_req <= 1'b1;
      step(4);
      check("ext_reset", {valid, b_oe[6:0]}, 8'h7F);
      @(posedge clk);
      rst_req <= 1'b0;
      wait_valid();
      check("fw_flag_clr", {7'h00, fw_flag}, 8'h00);
   endtask
   initial begin
      t_straps();
      t_uart();
      t_fifo();
      t_spi();
      t_gpio();
      t_reset();
      report_and_stop();
   end
endmodule
